// file: core/spe_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM pin front end.
// Assumes: Mode 0 or 3 host; the serial clock is the link clock domain.
// Notes:   Opcodes are shifted most significant bit first.
package spe_pkg;

   localparam logic [7:0] SPE_OP_WRITE_ENABLE_CMD  = 8'h06;
   localparam logic [7:0] SPE_OP_WRDI  = 8'h04;
   localparam logic [7:0] SPE_OP_RDSR  = 8'h05;
   localparam logic [7:0] SPE_OP_STATUS_WRITE_CMD  = 8'h01;
   localparam logic [7:0] SPE_OP_READ  = 8'h03;
   localparam logic [7:0] SPE_OP_WRITE = 8'h02;

   localparam int SPE_BIT_LOCK = 7;
   localparam int SPE_BIT_BPH  = 3;
   localparam int SPE_BIT_BPL  = 2;
   localparam int SPE_BIT_WEL  = 1;
   localparam int SPE_BIT_BUSY = 0;

   localparam logic [2:0] SPE_NV_RESET  = 3'h0;
   localparam int         SPE_WRITE_MS  = 5;
   localparam int         SPE_CLK_HZ    = 20000000;
   localparam int         SPE_WRITE_CYC = SPE_WRITE_MS * (SPE_CLK_HZ / 1000);
   localparam int         SPE_FIFO_W    = 8;
   localparam int         SPE_FIFO_D    = 4;

   typedef enum logic [2:0] {
      SPE_ST_CMD   = 3'b000,
      SPE_ST_ADDR  = 3'b001,
      SPE_ST_WDATA = 3'b010,
      SPE_ST_RDOUT = 3'b011,
      SPE_ST_SRIN  = 3'b100,
      SPE_ST_DEAD  = 3'b101
   } spe_state_e;

   // One received byte handed from the link domain to the core.
   typedef struct packed {
      logic       is_sr;
      logic [7:0] data;
   } spe_word_s;

   // Command committed at chip deselect.
   typedef struct packed {
      logic [2:0] kind;
      logic [7:0] sr_val;
   } spe_commit_s;

   localparam logic [2:0] SPE_K_NONE = 3'h0;
   localparam logic [2:0] SPE_K_WRITE_ENABLE_CMD = 3'h1;
   localparam logic [2:0] SPE_K_WRDI = 3'h2;
   localparam logic [2:0] SPE_K_STATUS_WRITE_CMD = 3'h3;
   localparam logic [2:0] SPE_K_WRIT = 3'h4;

endpackage : spe_pkg

// file: core/spe_front_end.sv
// Purpose: Pin front end of an SPI serial EEPROM: select, shift, pause, protect.
// Assumes: Host clock sck clocks the link logic; ref_clk runs the write timer.
// Notes:   Status and protect bits live in the ref_clk domain and are crossed.
// What this block does
// R1: Chip select high: deselected, output floats.
// R2: Idle and not writing means standby.
// R3: Host sends opcode after select falls.
// R4: Input bits captured on rising clock.
// R5: Output changes only on falling clock.
// R6: Pause suspends transfer, keeps transaction state.
// R7: Paused: output floats, clock/input ignored.
// R8: Host keeps select low while paused.
// R9: Protect pin and block bits guard writes.
// R10: Opcode is eight bits, MSB first.
// R11: Unknown opcode ignored until reselect.
// R12: Busy bit reads one while writing.
// R13: Lock bit with protect low rejects status writes.
// R14: Host polls busy before next write.
module spe_fifo #(
   parameter int W = 9,
   parameter int D = 4
) (
   // Clocks and reset
   input  wire logic         in_clk,
   input  wire logic         out_clk,
   input  wire logic         rstn,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   // Depth is a power of two of at least four; pointers cross in gray code.
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_q [D];
   logic [AW:0]   wb_q;
   logic [AW:0]   wg_q;
   logic [AW:0]   rb_q;
   logic [AW:0]   rg_q;
   logic [AW:0]   rg_s1_q;
   logic [AW:0]   rg_s2_q;
   logic [AW:0]   wg_s1_q;
   logic [AW:0]   wg_s2_q;
   logic [AW:0]   wb_next;
   logic [AW:0]   rb_next;
   logic          push;
   logic          pop;

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign wb_next   = wb_q + (AW+1)'(push);
   assign rb_next   = rb_q + (AW+1)'(pop);
   assign in_ready  = (wg_q != {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});
   assign out_valid = (rg_q != wg_s2_q);
   assign out_data  = mem_q[rb_q[AW-1:0]];

   // Fill side; the read pointer is seen late, which only makes it cautious.
   always_ff @(posedge in_clk or negedge rstn) begin
      if (!rstn) begin
         wb_q    <= '0;
         wg_q    <= '0;
         rg_s1_q <= '0;
         rg_s2_q <= '0;
      end else begin
         if (push) begin
            wb_q <= wb_next;
            wg_q <= wb_next ^ (wb_next >> 1);
         end
         rg_s1_q <= rg_q;
         rg_s2_q <= rg_s1_q;
      end
   end

   // Drain side; the write pointer arrives through two flip-flops.
   always_ff @(posedge out_clk or negedge rstn) begin
      if (!rstn) begin
         rb_q    <= '0;
         rg_q    <= '0;
         wg_s1_q <= '0;
         wg_s2_q <= '0;
      end else begin
         if (pop) begin
            rb_q <= rb_next;
            rg_q <= rb_next ^ (rb_next >> 1);
         end
         wg_s1_q <= wg_q;
         wg_s2_q <= wg_s1_q;
      end
   end

   always_ff @(posedge in_clk) begin
      if (push) begin
         mem_q[wb_q[AW-1:0]] <= in_data;
      end
   end
endmodule // spe_fifo

module spe_front_end
   import spe_pkg::*;
#(
   parameter int WRITE_CYC = SPE_WRITE_CYC
) (
   // System clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   // Serial pins
   input  wire logic       sck,
   input  wire logic       cs_n,
   input  wire logic       si,
   input  wire logic       hold_n,
   input  wire logic       wp_n,
   output logic            so_o,
   output logic            so_oe_n,
   // Memory-side stream and status
   output logic            wr_valid,
   input  wire logic       wr_ready,
   output logic [7:0]      wr_data,
   output logic            standby,
   output logic            write_busy_flag,
   output logic            hardware_protect_mode,
   output logic [1:0]      block_protect
);
   // ---------------- link domain (sck) ----------------
   spe_state_e  st_q;
   logic [7:0]  sh_q;
   logic [2:0]  bit_q;
   logic [7:0]  op_q;
   logic [4:0]  acnt_q;
   logic [7:0]  sr_tx_q;
   logic        so_q;
   logic        ev_tgl_q;
   logic        fifo_ov;
   logic        fifo_or;
   spe_word_s   fifo_od;
   logic        wel_q;
   logic [2:0]  nv_q;
   spe_commit_s cm_q;
   logic        wf_valid;
   logic        wf_ready;
   spe_word_s   wf_word;
   logic [7:0]  sr_link_s1_q;
   logic [7:0]  sr_link_q;
   logic [7:0]  sh_next;

   assign sh_next = {sh_q[6:0], si};

   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         sr_link_s1_q <= '0;
         sr_link_q    <= '0;
      end else begin
         sr_link_s1_q <= {nv_q[2], 3'h0, nv_q[1:0], wel_q, write_busy_flag};
         sr_link_q    <= sr_link_s1_q;
      end
   end

   // Shift engine; chip select high restarts every transaction.
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin // R1
         st_q   <= SPE_ST_CMD;
         bit_q  <= '0;
         sh_q   <= '0;
         op_q   <= '0;
         acnt_q <= '0;
      end else if (hold_n) begin // R6 R7
         sh_q  <= sh_next; // R4
         bit_q <= bit_q + 3'h1;
         if (bit_q == 3'h7) begin // R10
            case (st_q)
               SPE_ST_CMD: begin
                  op_q <= sh_next;
                  case (sh_next)
                     SPE_OP_RDSR:              st_q <= SPE_ST_RDOUT;
                     SPE_OP_STATUS_WRITE_CMD:              st_q <= SPE_ST_SRIN;
                     SPE_OP_READ, SPE_OP_WRITE: st_q <= SPE_ST_ADDR;
                     SPE_OP_WRITE_ENABLE_CMD, SPE_OP_WRDI: st_q <= SPE_ST_DEAD;
                     default:                  st_q <= SPE_ST_DEAD; // R11
                  endcase
               end
               SPE_ST_ADDR: begin
                  acnt_q <= acnt_q + 5'h1;
                  if (acnt_q[0]) begin
                     st_q <= (op_q == SPE_OP_WRITE) ? SPE_ST_WDATA : SPE_ST_RDOUT;
                  end
               end
               SPE_ST_SRIN: st_q <= SPE_ST_DEAD;
               default:     st_q <= st_q;
            endcase
         end else if (st_q == SPE_ST_CMD || st_q == SPE_ST_DEAD) begin
            op_q <= (bit_q == 3'h0) ? op_q : op_q;
         end
      end
   end

   assign wf_valid     = !cs_n && hold_n && (bit_q == 3'h7)
                         && (st_q == SPE_ST_WDATA || st_q == SPE_ST_SRIN);
   assign wf_word.is_sr = (st_q == SPE_ST_SRIN);
   assign wf_word.data  = sh_next;

   // Commit request is latched as data and signalled by toggling on deselect.
   always_ff @(posedge sck or negedge rstn) begin
      if (!rstn) begin
         cm_q <= '0;
      end else if (!cs_n && bit_q == 3'h7 && hold_n) begin
         case (st_q)
            SPE_ST_CMD: cm_q.kind <= (sh_next == SPE_OP_WRITE_ENABLE_CMD) ? SPE_K_WRITE_ENABLE_CMD :
                                     (sh_next == SPE_OP_WRDI) ? SPE_K_WRDI : SPE_K_NONE;
            SPE_ST_SRIN:  cm_q <= '{kind: SPE_K_STATUS_WRITE_CMD, sr_val: sh_next};
            SPE_ST_WDATA: cm_q.kind <= SPE_K_WRIT;
            default:      cm_q.kind <= SPE_K_NONE;
         endcase
      end else if (!cs_n && bit_q == 3'h0 && hold_n && st_q != SPE_ST_WDATA) begin
         cm_q.kind <= SPE_K_NONE;
      end
   end

   always_ff @(posedge cs_n or negedge rstn) begin
      if (!rstn) begin
         ev_tgl_q <= 1'b0;
      end else begin
         ev_tgl_q <= !ev_tgl_q;
      end
   end

   // Output changes on falling clock only.
   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         so_q    <= 1'b0;
         sr_tx_q <= '0;
      end else if (hold_n && st_q == SPE_ST_RDOUT && op_q == SPE_OP_RDSR) begin // R5 R6
         so_q    <= (bit_q == 3'h0) ? sr_link_q[7] : sr_tx_q[7];
         sr_tx_q <= (bit_q == 3'h0) ? {sr_link_q[6:0], 1'b0} : {sr_tx_q[6:0], 1'b0};
      end
   end

   assign so_o    = so_q;
   assign so_oe_n = cs_n || !hold_n || st_q != SPE_ST_RDOUT; // R1 R7

   spe_fifo #(.W(SPE_FIFO_W + 1), .D(SPE_FIFO_D)) u_fifo (
      .in_clk    (sck),
      .out_clk   (ref_clk),
      .rstn      (rstn),
      .in_valid  (wf_valid),
      .in_ready  (wf_ready),
      .in_data   (wf_word),
      .out_valid (fifo_ov),
      .out_ready (fifo_or),
      .out_data  (fifo_od)
   );

   // ---------------- core domain (ref_clk) ----------------
   logic [2:0]  ev_sync_q;
   logic        cs_s1_q;
   logic        cs_s2_q;
   logic        wp_s1_q;
   logic        wp_s2_q;
   logic [31:0] tmr_q;
   logic        ev_pulse;

   // Status bytes are dropped from the stream so they never block it.
   assign fifo_or  = wr_ready || fifo_od.is_sr;
   assign wr_valid = fifo_ov && !fifo_od.is_sr;
   assign wr_data  = fifo_od.data;
   assign ev_pulse = ev_sync_q[2] ^ ev_sync_q[1];

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ev_sync_q <= '0;
         cs_s1_q   <= 1'b1;
         cs_s2_q   <= 1'b1;
         wp_s1_q   <= 1'b0;
         wp_s2_q   <= 1'b0;
      end else begin
         ev_sync_q <= {ev_sync_q[1:0], ev_tgl_q};
         cs_s1_q   <= cs_n;
         cs_s2_q   <= cs_s1_q;
         wp_s1_q   <= wp_n;
         wp_s2_q   <= wp_s1_q;
      end
   end

   assign hardware_protect_mode = nv_q[2] && !wp_s2_q; // R13
   assign block_protect         = nv_q[1:0]; // R9
   assign write_busy_flag       = (tmr_q != '0); // R12
   assign standby               = cs_s2_q && !write_busy_flag; // R2

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wel_q <= 1'b0;
         nv_q  <= SPE_NV_RESET;
         tmr_q <= '0;
      end else if (tmr_q != '0) begin
         tmr_q <= tmr_q - 32'h1;
         if (tmr_q == 32'h1) begin
            wel_q <= 1'b0;
         end
      end else if (ev_pulse) begin // R14
         case (cm_q.kind)
            SPE_K_WRITE_ENABLE_CMD: wel_q <= 1'b1;
            SPE_K_WRDI: wel_q <= 1'b0;
            SPE_K_STATUS_WRITE_CMD: if (wel_q && !hardware_protect_mode) begin // R13
               nv_q  <= {cm_q.sr_val[SPE_BIT_LOCK], cm_q.sr_val[SPE_BIT_BPH],
                         cm_q.sr_val[SPE_BIT_BPL]};
               tmr_q <= 32'(WRITE_CYC);
            end
            SPE_K_WRIT: if (wel_q && nv_q[1:0] == 2'h0) begin // R9
               tmr_q <= 32'(WRITE_CYC);
            end
            default: wel_q <= wel_q;
         endcase
      end
   end
endmodule // spe_front_end

// file: dv/spe_front_end_chk.sv
// Purpose: Assertions on the serial pins and status of the front end.
// Assumes: The host holds sck still outside frames.
// Notes:   Bound to every instance of the front end.
module spe_front_end_chk #(
   parameter int WRITE_CYC = 20
) (
   // Clocks and reset
   input wire logic       ref_clk,
   input wire logic       rstn,
   input wire logic       sck,
   // Pins
   input wire logic       cs_n,
   input wire logic       hold_n,
   input wire logic       wp_n,
   input wire logic       so_o,
   input wire logic       so_oe_n,
   // Status
   input wire logic       standby,
   input wire logic       write_busy_flag,
   input wire logic       hardware_protect_mode,
   input wire logic [1:0] block_protect
);
   logic so_rise_q;
   int   busy_cnt_q;
   always_ff @(posedge sck or negedge rstn) begin
      if (!rstn) so_rise_q <= 1'b0;
      else so_rise_q <= so_o;
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) busy_cnt_q <= 0;
      else busy_cnt_q <= write_busy_flag ? busy_cnt_q + 1 : 0;
   end
   sequence s_desel; cs_n [*2]; endsequence
   sequence s_quiet; (cs_n && !write_busy_flag) [*6]; endsequence
   sequence s_paused; !hold_n [*2]; endsequence
   property p_desel_float; @(posedge ref_clk) disable iff (!rstn) s_desel |-> so_oe_n; endproperty
   property p_standby; @(posedge ref_clk) disable iff (!rstn) s_quiet |-> standby; endproperty
   property p_active; @(posedge ref_clk) disable iff (!rstn) $fell(cs_n) |-> ##[1:4] !standby;
   endproperty
   property p_out_fall; @(negedge sck) disable iff (!rstn) !so_oe_n |-> so_o == so_rise_q;
   endproperty
   property p_pause_float; @(posedge sck) disable iff (!rstn) s_paused |-> so_oe_n; endproperty
   property p_busy_len; @(posedge ref_clk) disable iff (!rstn)
      $fell(write_busy_flag) |-> busy_cnt_q inside {[WRITE_CYC-1:WRITE_CYC+1]}; endproperty
   property p_busy_start; @(posedge ref_clk) disable iff (!rstn) $rose(write_busy_flag) |-> cs_n;
   endproperty
   property p_hpm_off; @(posedge ref_clk) disable iff (!rstn) wp_n [*4] |-> !hardware_protect_mode;
   endproperty
   property p_bp_guard; @(posedge ref_clk) disable iff (!rstn)
      $changed(block_protect) |-> !$past(hardware_protect_mode); endproperty
   a_desel_float: assert property (p_desel_float) else $error("so driven deselected");
   a_standby: assert property (p_standby) else $error("no standby");
   a_active: assert property (p_active) else $error("not active");
   a_out_fall: assert property (p_out_fall) else $error("so moved on rise");
   a_pause_float: assert property (p_pause_float) else $error("so driven in pause");
   a_busy_len: assert property (p_busy_len) else $error("busy length");
   a_busy_start: assert property (p_busy_start) else $error("busy while selected");
   a_hpm_off: assert property (p_hpm_off) else $error("protect mode with wp high");
   a_bp_guard: assert property (p_bp_guard) else $error("bits changed in protect");
endmodule // spe_front_end_chk
bind spe_front_end spe_front_end_chk #(.WRITE_CYC(WRITE_CYC)) u_chk (.ref_clk, .rstn, .sck,
   .cs_n, .hold_n, .wp_n, .so_o, .so_oe_n, .standby, .write_busy_flag, .hardware_protect_mode,
   .block_protect);

// file: dv/spe_host_model.sv
// Purpose: Host model driving select, serial clock, data and pause.
// Assumes: Mode 0 host; sck runs at 6 ns only inside frames.
// Notes:   A floating serial output reads back as the inverse of its last value.
module spe_host_model #(
   parameter int T_CSS = 90,
   parameter int T_CDS = 90
) (
   // Host pins
   output logic     sck,
   output logic     cs_n,
   output logic     si,
   output logic     hold_n,
   // Device output
   input wire logic so_o,
   input wire logic so_oe_n,
   // Pause observation
   output logic     hold_float
);
   timeunit 1ns;
   timeprecision 100ps;
   logic so_last;
   wire  so_w = so_oe_n ? !so_last : so_o;
   always @(so_o or so_oe_n) if (!so_oe_n) so_last = so_o;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      hold_n = 1'b1;
      hold_float = 1'b1;
      so_last = 1'b0;
   end
   task automatic frame(input logic [71:0] tx, input int n, input int h,
                        output logic [71:0] rx);
      rx = '0;
      hold_float = 1'b1;
      cs_n <= 1'b0;
      #T_CSS;
      for (int i = n - 1; i >= 0; i--) begin
         if (i == h) begin
            #3 hold_n <= 1'b0;
            repeat (4) begin
               #3 sck <= 1'b1;
               si <= !si;
               #3 hold_float &= so_oe_n;
               sck <= 1'b0;
            end
            #3 hold_n <= 1'b1;
         end
         si <= tx[i];
         #3 sck <= 1'b1;
         rx = {rx[70:0], so_w};
         #3 sck <= 1'b0;
      end
      #3 cs_n <= 1'b1;
      si <= !si;
      #T_CDS;
   endtask
endmodule // spe_host_model

// file: dv/spe_front_end_bench.sv
// Purpose: Self-checking bench for the serial EEPROM pin front end.
// Assumes: The write time is shortened to 20 cycles.
// Notes:   The write stream is stalled, then drained.
module spe_front_end_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import spe_pkg::*;
   localparam int WC = 20;
   logic        ref_clk, rstn, wp_n, wr_ready;
   logic [71:0] rx;
   int          n_errors = 0, checks_done = 0, cyc = 0, n;
   wire         sck, cs_n, si, hold_n, so_o, so_oe_n, hold_float;
   wire         wr_valid, standby, write_busy_flag, hardware_protect_mode;
   wire [7:0]   wr_data;
   wire [1:0]   block_protect;
   spe_front_end #(.WRITE_CYC(WC)) u_spe_front_end (.ref_clk, .rstn, .sck, .cs_n, .si, .hold_n,
      .wp_n, .so_o, .so_oe_n, .wr_valid, .wr_ready, .wr_data, .standby, .write_busy_flag,
      .hardware_protect_mode, .block_protect);
   spe_host_model u_spe_host_model (.sck, .cs_n, .si, .hold_n, .so_o, .so_oe_n, .hold_float);
   task automatic idle(input int k);
      repeat (k) @(negedge ref_clk);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic xf(input logic [71:0] tx, input int nb, input int h = -1);
      u_spe_host_model.frame(tx, nb, h, rx);
      idle(4);
   endtask
   task automatic rdsr(input logic [7:0] exp, input string what);
      xf(72'({SPE_OP_RDSR, 8'h00}), 16);
      chk(rx[7:0], exp, what);
   endtask
   task automatic poll;
      rx = '1;
      for (int k = 0; k < 40 && rx[0] !== 1'b0; k++) xf(72'({SPE_OP_RDSR, 8'h00}), 16);
      chk(8'(rx[0]), 8'h00, "poll");
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic t_status;
      chk({5'h0, standby, so_oe_n, write_busy_flag}, 8'h06, "idle pins");
      rdsr(8'h00, "sr reset");
      xf(72'(SPE_OP_WRITE_ENABLE_CMD), 8);
      rdsr(8'h02, "wel set");
      xf(72'(SPE_OP_WRDI), 8);
      rdsr(8'h00, "wel clear");
      xf(72'({8'hA5, SPE_OP_WRITE_ENABLE_CMD}), 16);
      rdsr(8'h00, "bad op");
      $display("test status done");
   endtask
   task automatic t_protect;
      xf(72'(SPE_OP_WRITE_ENABLE_CMD), 8);
      xf(72'({SPE_OP_STATUS_WRITE_CMD, 8'h8C}), 16);
      chk(8'(write_busy_flag), 8'h01, "busy");
      rdsr(8'h8F, "sr busy");
      poll;
      rdsr(8'h8C, "sr written");
      @(posedge ref_clk) wp_n <= 1'b0;
      idle(4);
      chk(8'(hardware_protect_mode), 8'h01, "protect on");
      xf(72'(SPE_OP_WRITE_ENABLE_CMD), 8);
      xf(72'({SPE_OP_STATUS_WRITE_CMD, 8'h00}), 16);
      chk({5'h0, write_busy_flag, block_protect}, 8'h03, "locked");
      @(posedge ref_clk) wp_n <= 1'b1;
      xf(72'(SPE_OP_WRITE_ENABLE_CMD), 8);
      xf(72'({SPE_OP_STATUS_WRITE_CMD, 8'h00}), 16);
      poll;
      chk({6'h0, block_protect}, 8'h00, "unlocked");
      $display("test protect done");
   endtask
   task automatic t_pause;
      for (int h = 3; h <= 12; h += 9) begin
         xf(72'({SPE_OP_RDSR, 8'h00}), 16, h);
         chk(rx[7:0], 8'h00, "resumed");
         chk(8'(hold_float), 8'h01, "paused float");
      end
      $display("test pause done");
   endtask
   task automatic t_stream;
      @(posedge ref_clk) wr_ready <= 1'b0;
      xf(72'(SPE_OP_WRITE_ENABLE_CMD), 8);
      xf({SPE_OP_WRITE, 16'h0000, 48'h112233445566}, 72);
      chk(8'(wr_valid), 8'h01, "stalled");
      n = 0;
      @(posedge ref_clk) wr_ready <= 1'b1;
      repeat (40) begin
         @(negedge ref_clk);
         if (wr_valid === 1'b1) begin
            chk(wr_data, 8'(8'h11 * (n + 1)), "stream");
            n++;
         end
      end
      chk(8'(n), 8'(SPE_FIFO_D), "depth");
      poll;
      $display("test stream done");
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         $display("unexpected at %0t: timeout", $time);
         close_out;
      end
   end
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      rstn = 1'b0;
      wp_n = 1'b1;
      wr_ready = 1'b1;
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      idle(3);
      t_status;
      t_protect;
      t_pause;
      t_stream;
      close_out;
   end
endmodule // spe_front_end_bench
